/* common/esc_pkg.sv */
package esc_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int         ESC_ADDR_W     = 8;
   localparam int         ESC_DATA_W     = 8;
   localparam logic [7:0] OFS_SHAPE_KIND = 8'h1d;
   localparam logic [7:0] OFS_SHAPE_PARM = 8'h1e;
   localparam logic [7:0] OFS_SHAPE_SPAN = 8'h1f;
   localparam logic [7:0] OFS_RESID_848  = 8'h20;

   // ---------------------------------------------------------------
   // field positions and writable masks
   // ---------------------------------------------------------------
   localparam int         KIND_FALL_LSB  = 4;
   localparam int         KIND_RISE_LSB  = 0;
   localparam int         PARM_FALL_LSB  = 4;
   localparam int         PARM_RISE_LSB  = 0;
   localparam int         SPAN_SCALE_BIT = 7;
   localparam int         SPAN_CNT_LSB   = 0;
   localparam int         SPAN_CNT_W     = 5;
   localparam logic [7:0] PARM_WR_MASK   = 8'h77;
   localparam logic [7:0] SPAN_WR_MASK   = 8'h9f;

   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_SHAPE_KIND = 8'h11;
   localparam logic [7:0] RST_SHAPE_PARM = 8'h00;
   localparam logic [7:0] RST_SHAPE_SPAN = 8'h04;
   localparam logic [7:0] RST_RESID_848  = 8'h00;

   // ---------------------------------------------------------------
   // style codes and levels
   // ---------------------------------------------------------------
   localparam logic [3:0] STYLE_LIN1       = 4'h1;
   localparam logic [3:0] STYLE_LIN2       = 4'h2;
   localparam logic [3:0] STYLE_LIN3       = 4'h3;
   localparam logic [3:0] STYLE_LUT_FIXED  = 4'h4;
   localparam logic [3:0] STYLE_LUT_CORR   = 4'h5;
   localparam logic [3:0] STYLE_LUT_NOCORR = 4'h6;
   localparam logic [7:0] AMP_FULL         = 8'hff;

   typedef enum logic [1:0] {
      ST_HIGH = 2'b00,
      ST_FALL = 2'b01,
      ST_LOW  = 2'b10,
      ST_RISE = 2'b11
   } esc_phase_type;

   typedef struct packed {
      logic [7:0]            kind;
      logic [7:0]            parm;
      logic [7:0]            span;
      logic [7:0]            resid;
      logic [7:0]            rdata;
      logic [7:0]            sup_meta;
      logic [7:0]            sup_sync;
      esc_phase_type         phase;
      logic [SPAN_CNT_W-1:0] step;
      logic                  half;
      logic [7:0]            amp;
      logic                  busy;
      logic                  err;
   } esc_regs_type;

   function automatic logic esc_style_ok(input logic [3:0] code);
      return (code >= STYLE_LIN1) && (code <= STYLE_LUT_NOCORR);
   endfunction

endpackage

/* dv/esc_edge_shaper_tb.sv */
`timescale 1ns/1ps

module esc_edge_shaper_tb;
   import esc_pkg::*;

   // ------
   // signals and bench model
   // ------
   logic                  clk_sys_i;
   logic                  sys_rst_i;
   logic [ESC_ADDR_W-1:0] addr_i;
   logic [ESC_DATA_W-1:0] wdata_i;
   logic                  wr_i;
   logic                  rd_i;
   logic [ESC_DATA_W-1:0] rdata_o;
   logic                  mod_i;
   logic [7:0]            power_amplifier_supply_i;
   logic [7:0]            amp_o;
   logic                  busy_o;
   logic                  style_err_o;
   int                    miscompares;
   int                    comparisons;
   logic [15:0]           lfsr;
   logic [7:0]            model_reg [4];
   logic [7:0]            kinds [6] = '{8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'h61};
   logic [7:0]            spans [6] = '{8'h00, 8'h01, 8'h1f, 8'h81, 8'h9f, 8'hff};
   logic [7:0]            unmapped [4] = '{8'h00, 8'h1c, 8'h21, 8'hff};

   esc_edge_shaper DUT (
      .clk_sys_i                (clk_sys_i),
      .sys_rst_i                (sys_rst_i),
      .addr_i                   (addr_i),
      .wdata_i                  (wdata_i),
      .wr_i                     (wr_i),
      .rd_i                     (rd_i),
      .rdata_o                  (rdata_o),
      .mod_i                    (mod_i),
      .power_amplifier_supply_i (power_amplifier_supply_i),
      .amp_o                    (amp_o),
      .busy_o                   (busy_o),
      .style_err_o              (style_err_o)
   );

   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ------
   // helpers and compares
   // ------
   function automatic logic [7:0] rnd8();
      repeat (8) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction

   function automatic logic bad(input logic [3:0] c);
      return !(c >= 4'h1 && c <= 4'h6);
   endfunction

   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic chk_n(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // ------
   // register port, entered and left at a rising edge
   // ------
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
      if (a >= OFS_SHAPE_KIND && a <= OFS_RESID_848)
         model_reg[a - OFS_SHAPE_KIND] = (a == OFS_SHAPE_PARM) ? (d & PARM_WR_MASK) :
                                         (a == OFS_SHAPE_SPAN) ? (d & SPAN_WR_MASK) : d;
      @(posedge clk_sys_i);
   endtask

   task automatic reg_rd(input logic [7:0] a);
      logic [7:0] exp;
      exp = (a >= OFS_SHAPE_KIND && a <= OFS_RESID_848) ? model_reg[a - OFS_SHAPE_KIND] : 8'h00;
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      #1;
      chk8(rdata_o, exp, "read data");
      @(posedge clk_sys_i);
      #1;
      chk8(rdata_o, 8'h00, "read data after slot");
      @(posedge clk_sys_i);
   endtask

   task automatic model_rst();
      model_reg = '{RST_SHAPE_KIND, RST_SHAPE_PARM, RST_SHAPE_SPAN, RST_RESID_848};
   endtask

   // ------
   // edge watcher: counts busy cycles, drop_at toggles mod_i mid-edge
   // ------
   task automatic watch(input int exp_n, input logic [7:0] end_amp, input logic exp_err,
                        input int drop_at);
      int         n;
      logic [7:0] prev;
      logic       up;
      n = 0;
      up = (end_amp == AMP_FULL);
      prev = amp_o;
      @(posedge clk_sys_i);
      #1;
      while (busy_o === 1'b1 && n < 100)
      begin
         n++;
         chk1(amp_o >= model_reg[3], 1'b1, "amplitude below residual");
         if (model_reg[2][SPAN_SCALE_BIT] && n % 2 == 0)
            chk8(amp_o, prev, "state not held two cycles");
         chk1(up ? amp_o >= prev : amp_o <= prev, 1'b1, "edge went back");
         prev = amp_o;
         @(posedge clk_sys_i);
         if (n == drop_at)
            mod_i <= ~mod_i;
         #1;
      end
      if (n >= 100)
      begin
         miscompares++;
         $display("wrong value at %0t: edge never ended", $time);
         close_out();
      end
      chk_n(n, exp_n, "edge length");
      chk8(amp_o, end_amp, "end level");
      chk1(style_err_o, exp_err, "style error");
   endtask

   task automatic edge_run(input logic lvl, input logic exp_err);
      int n;
      n = exp_err ? 0 : int'(model_reg[2][4:0]) * (model_reg[2][SPAN_SCALE_BIT] ? 2 : 1);
      // supply settles through the synchroniser before the edge starts
      power_amplifier_supply_i <= rnd8();
      repeat (3) @(posedge clk_sys_i);
      mod_i                    <= lvl;
      watch(n, lvl ? model_reg[3] : AMP_FULL, exp_err, 0);
      @(posedge clk_sys_i);
   endtask

   // ------
   // watchdog
   // ------
   initial
   begin
      #500000;
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      close_out();
   end

   // ------
   // main sequence
   // ------
   initial
   begin
      lfsr = 16'd63069;
      sys_rst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      mod_i = 1'b0;
      power_amplifier_supply_i = 8'h80;
      miscompares = 0;
      comparisons = 0;
      model_rst();
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      chk8(amp_o, AMP_FULL, "amplitude after reset");
      for (int a = 8'h1d; a <= 8'h20; a++) reg_rd(8'(a));
      $display("test reset values done");

      // all-ones write exposes reserved bits, random write the rest
      for (int a = 8'h1d; a <= 8'h20; a++)
      begin
         reg_wr(8'(a), 8'hff);
         reg_rd(8'(a));
         reg_wr(8'(a), rnd8());
         reg_rd(8'(a));
      end
      foreach (unmapped[i])
      begin
         reg_wr(unmapped[i], rnd8());
         reg_rd(unmapped[i]);
      end
      for (int a = 8'h1d; a <= 8'h20; a++) reg_rd(8'(a));
      $display("test register access done");

      reg_wr(OFS_SHAPE_SPAN, 8'h03);
      reg_wr(OFS_RESID_848, rnd8());
      for (int c = 0; c < 16; c++)
      begin
         reg_wr(OFS_SHAPE_PARM, rnd8());
         reg_wr(OFS_SHAPE_KIND, {4'(c), STYLE_LIN1});
         edge_run(1'b1, bad(4'(c)));
         edge_run(1'b0, 1'b0);
         reg_wr(OFS_SHAPE_KIND, {STYLE_LIN1, 4'(c)});
         edge_run(1'b1, 1'b0);
         edge_run(1'b0, bad(4'(c)));
      end
      $display("test style codes done");

      foreach (kinds[i])
      begin
         reg_wr(OFS_SHAPE_KIND, kinds[i]);
         reg_wr(OFS_SHAPE_SPAN, spans[i]);
         reg_wr(OFS_RESID_848, (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd8());
         edge_run(1'b1, 1'b0);
         edge_run(1'b0, 1'b0);
      end
      $display("test length and scaling done");

      // mod_i reversal mid-edge must not cut the edge short
      reg_wr(OFS_SHAPE_KIND, 8'h22);
      reg_wr(OFS_SHAPE_SPAN, 8'h06);
      mod_i <= 1'b1;
      watch(6, model_reg[3], 1'b0, 2);
      watch(6, AMP_FULL, 1'b0, 0);
      @(posedge clk_sys_i);
      edge_run(1'b1, 1'b0);
      reg_wr(OFS_RESID_848, rnd8());
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk8(amp_o, model_reg[3], "low level follows residual");
      @(posedge clk_sys_i);
      edge_run(1'b0, 1'b0);
      $display("test mid-edge changes done");

      // reset in the middle of a long edge
      reg_wr(OFS_SHAPE_SPAN, 8'h9f);
      mod_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      mod_i     <= 1'b0;
      #1;
      chk8(amp_o, AMP_FULL, "amplitude in reset");
      chk1(busy_o, 1'b0, "busy in reset");
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      model_rst();
      for (int a = 8'h1d; a <= 8'h20; a++) reg_rd(8'(a));
      edge_run(1'b1, 1'b0);
      $display("test mid-run reset done");
      close_out();
   end

endmodule // esc_edge_shaper_tb

/* hdl/esc_edge_shaper.sv */
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module esc_edge_shaper
   import esc_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  sys_rst_i,
   // register port
   input  wire logic [ESC_ADDR_W-1:0] addr_i,
   input  wire logic [ESC_DATA_W-1:0] wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [ESC_DATA_W-1:0] rdata_o,
   // modulation request, high while carrier is to be reduced
   input  wire logic                  mod_i,
   // power amplifier supply level, asynchronous pin
   input  wire logic [7:0]            power_amplifier_supply_i,
   // carrier amplitude and status
   output logic      [7:0]            amp_o,
   output logic                       busy_o,
   output logic                       style_err_o
);

   import esc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   esc_regs_type r_ff;
   esc_regs_type nxt_r;

   logic [3:0]            fall_style;
   logic [3:0]            rise_style;
   logic [3:0]            edge_style;
   logic [2:0]            edge_cfg;
   logic [SPAN_CNT_W-1:0] cnt;
   logic                  scale;
   logic                  tick;
   logic                  last;
   logic [SPAN_CNT_W-1:0] step_inc;
   logic [15:0]           prog_w;
   logic [7:0]            prog;
   logic [7:0]            weight;
   logic [15:0]           swing;
   logic [7:0]            delta;

   assign fall_style = r_ff.kind[KIND_FALL_LSB +: 4];
   assign rise_style = r_ff.kind[KIND_RISE_LSB +: 4];
   assign edge_style = (r_ff.phase == ST_RISE) ? rise_style : fall_style;
   assign edge_cfg   = (r_ff.phase == ST_RISE) ? r_ff.parm[PARM_RISE_LSB +: 3]
                                               : r_ff.parm[PARM_FALL_LSB +: 3];
   assign cnt        = r_ff.span[SPAN_CNT_LSB +: SPAN_CNT_W];
   assign scale      = r_ff.span[SPAN_SCALE_BIT];
   assign tick       = !scale || r_ff.half;
   assign step_inc   = r_ff.step + 5'h01;
   assign last       = (step_inc == cnt);

   // progress of the state about to be shown, 0..255 across the edge
   always_comb
   begin
      if (cnt == 5'h00)
         prog_w = 16'h0000;
      else
         prog_w = (16'(step_inc) * 16'h00ff) / 16'(cnt);
      prog = prog_w[7:0];
   end

   // ---------------------------------------------------------------
   // shaping curve
   // ---------------------------------------------------------------
   esc_shape_weight u_weight (
      .style_i  (edge_style),
      .cfg_i    (edge_cfg),
      .prog_i   (prog),
      .supply_i (r_ff.sup_sync),
      .weight_o (weight)
   );

   // linear scaling of the swing between full and residual
   assign swing = (16'(AMP_FULL - r_ff.resid) * 16'(weight)) >> 8;
   assign delta = swing[7:0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_r          = r_ff;
      nxt_r.sup_meta = power_amplifier_supply_i;
      nxt_r.sup_sync = r_ff.sup_meta;
      nxt_r.rdata    = 8'h00;

      if (rd_i)
      begin
         unique case (addr_i)
            OFS_SHAPE_KIND: nxt_r.rdata = r_ff.kind;
            OFS_SHAPE_PARM: nxt_r.rdata = r_ff.parm;
            OFS_SHAPE_SPAN: nxt_r.rdata = r_ff.span;
            OFS_RESID_848:  nxt_r.rdata = r_ff.resid;
            default:        nxt_r.rdata = 8'h00;
         endcase
      end

      if (wr_i)
      begin
         unique case (addr_i)
            OFS_SHAPE_KIND: nxt_r.kind  = wdata_i;
            OFS_SHAPE_PARM: nxt_r.parm  = wdata_i & PARM_WR_MASK;
            OFS_SHAPE_SPAN: nxt_r.span  = wdata_i & SPAN_WR_MASK;
            OFS_RESID_848:  nxt_r.resid = wdata_i;
            default:        nxt_r.resid = r_ff.resid;
         endcase
      end

      // an edge in progress always completes before the next one starts
      unique case (r_ff.phase)
         ST_HIGH:
         begin
            nxt_r.amp = AMP_FULL;
            if (mod_i)
            begin
               nxt_r.err = !esc_style_ok(fall_style);
               if (cnt == 5'h00 || !esc_style_ok(fall_style))
               begin
                  nxt_r.phase = ST_LOW;
                  nxt_r.amp   = r_ff.resid;
               end
               else
               begin
                  nxt_r.phase = ST_FALL;
                  nxt_r.step  = 5'h00;
                  nxt_r.half  = 1'b0;
                  nxt_r.busy  = 1'b1;
               end
            end
         end
         ST_FALL:
         begin
            nxt_r.half = scale ? !r_ff.half : 1'b0;
            if (tick)
            begin
               if (last)
               begin
                  nxt_r.phase = ST_LOW;
                  nxt_r.amp   = r_ff.resid;
                  nxt_r.busy  = 1'b0;
               end
               else
               begin
                  nxt_r.step = step_inc;
                  nxt_r.amp  = AMP_FULL - delta;
               end
            end
         end
         ST_LOW:
         begin
            nxt_r.amp = r_ff.resid;
            if (!mod_i)
            begin
               nxt_r.err = !esc_style_ok(rise_style);
               if (cnt == 5'h00 || !esc_style_ok(rise_style))
               begin
                  nxt_r.phase = ST_HIGH;
                  nxt_r.amp   = AMP_FULL;
               end
               else
               begin
                  nxt_r.phase = ST_RISE;
                  nxt_r.step  = 5'h00;
                  nxt_r.half  = 1'b0;
                  nxt_r.busy  = 1'b1;
               end
            end
         end
         ST_RISE:
         begin
            nxt_r.half = scale ? !r_ff.half : 1'b0;
            if (tick)
            begin
               if (last)
               begin
                  nxt_r.phase = ST_HIGH;
                  nxt_r.amp   = AMP_FULL;
                  nxt_r.busy  = 1'b0;
               end
               else
               begin
                  nxt_r.step = step_inc;
                  nxt_r.amp  = r_ff.resid + delta;
               end
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         r_ff.kind     <= RST_SHAPE_KIND;
         r_ff.parm     <= RST_SHAPE_PARM;
         r_ff.span     <= RST_SHAPE_SPAN;
         r_ff.resid    <= RST_RESID_848;
         r_ff.rdata    <= 8'h00;
         r_ff.sup_meta <= 8'h00;
         r_ff.sup_sync <= 8'h00;
         r_ff.phase    <= ST_HIGH;
         r_ff.step     <= 5'h00;
         r_ff.half     <= 1'b0;
         r_ff.amp      <= AMP_FULL;
         r_ff.busy     <= 1'b0;
         r_ff.err      <= 1'b0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   assign rdata_o     = r_ff.rdata;
   assign amp_o       = r_ff.amp;
   assign busy_o      = r_ff.busy;
   assign style_err_o = r_ff.err;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   fall_start_a: assert property (
      (r_ff.phase == ST_HIGH) && mod_i && (cnt != 5'h00) && esc_style_ok(fall_style)
      |=> (r_ff.phase == ST_FALL) && busy_o && (amp_o == AMP_FULL))
      else $error("falling edge did not start");

   bad_fall_style_a: assert property (
      (r_ff.phase == ST_HIGH) && mod_i && !esc_style_ok(fall_style)
      |=> (r_ff.phase == ST_LOW) && style_err_o && (amp_o == $past(r_ff.resid)))
      else $error("reserved falling style not treated as abrupt");

   bad_rise_style_a: assert property (
      (r_ff.phase == ST_LOW) && !mod_i && !esc_style_ok(rise_style)
      |=> (r_ff.phase == ST_HIGH) && style_err_o && (amp_o == AMP_FULL))
      else $error("reserved rising style not treated as abrupt");

   scaled_hold_a: assert property (
      (r_ff.phase inside {ST_FALL, ST_RISE}) && scale && !r_ff.half && !wr_i
      |=> $stable(r_ff.step) && $stable(amp_o))
      else $error("scaled state changed after one cycle");

   plain_step_a: assert property (
      (r_ff.phase inside {ST_FALL, ST_RISE}) && !scale && !last && !wr_i
      |=> (r_ff.step == $past(step_inc)))
      else $error("unscaled state did not advance");

   edge_end_a: assert property (
      (r_ff.phase == ST_FALL) && tick && last
      |=> (r_ff.phase == ST_LOW) && !busy_o && (amp_o == $past(r_ff.resid)))
      else $error("falling edge did not end on residual");

   rise_end_a: assert property (
      (r_ff.phase == ST_RISE) && tick && last
      |=> (r_ff.phase == ST_HIGH) && !busy_o && (amp_o == AMP_FULL))
      else $error("rising edge did not end on full carrier");

   err_clear_a: assert property (
      (r_ff.phase == ST_LOW) && !mod_i && esc_style_ok(rise_style) |=> !style_err_o)
      else $error("valid rising style left the error flag set");

   low_level_a: assert property (
      (r_ff.phase == ST_LOW) && mod_i |=> (amp_o == $past(r_ff.resid)))
      else $error("modulated level not residual");

   high_level_a: assert property (
      (r_ff.phase == ST_HIGH) |-> (amp_o == AMP_FULL) && !busy_o)
      else $error("idle level not full carrier");

   rsvd_read_a: assert property (
      rd_i && (addr_i == OFS_SHAPE_PARM) |=> (rdata_o[7] == 1'b0) && (rdata_o[3] == 1'b0))
      else $error("reserved edge parameter bits read as one");

   fall_done_c: cover property (
      (r_ff.phase == ST_FALL) ##1 (r_ff.phase == ST_LOW));
   rise_done_c: cover property (
      (r_ff.phase == ST_RISE) ##1 (r_ff.phase == ST_HIGH));
   scaled_edge_c: cover property (
      (r_ff.phase == ST_FALL) && scale && last && tick);
   lut_edge_c: cover property (
      (r_ff.phase == ST_RISE) && (rise_style == STYLE_LUT_CORR));

endmodule // esc_edge_shaper

/* hdl/esc_shape_weight.sv */
`timescale 1ns/1ps

module esc_shape_weight
   import esc_pkg::*;
(
   // selection
   input  wire logic [3:0] style_i,
   input  wire logic [2:0] cfg_i,
   // progress along the edge and supply level
   input  wire logic [7:0] prog_i,
   input  wire logic [7:0] supply_i,
   // shaped weight, 0 = start level, 255 = end level
   output logic      [7:0] weight_o
);

   // ---------------------------------------------------------------
   // four shaping tables, eight points each
   // ---------------------------------------------------------------
   localparam logic [3:0][7:0][7:0] SHAPE_LUT = '{
      '{8'hff, 8'hfe, 8'hf8, 8'he8, 8'hc0, 8'h80, 8'h40, 8'h10},
      '{8'hff, 8'hf0, 8'hd0, 8'ha0, 8'h70, 8'h40, 8'h20, 8'h08},
      '{8'hff, 8'hf6, 8'hd9, 8'hb0, 8'h80, 8'h50, 8'h27, 8'h0a},
      '{8'hff, 8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20}
   };

   logic [15:0] knee;
   logic [15:0] tmp;
   logic [7:0]  base;

   always_comb
   begin
      knee     = 16'h0080 + {9'h000, cfg_i, 4'h0};
      tmp      = 16'h0000;
      base     = SHAPE_LUT[cfg_i[1:0]][prog_i[7:5]];
      weight_o = prog_i;
      unique case (style_i)
         STYLE_LIN1:       weight_o = prog_i;
         STYLE_LIN2:
         begin
            // time constant moves the knee at mid edge
            if (prog_i < 8'h80)
               tmp = (16'(prog_i) * knee) >> 7;
            else
               tmp = knee + (((16'(prog_i) - 16'h0080) * (16'h00ff - knee)) >> 7);
            weight_o = tmp[7:0];
         end
         STYLE_LIN3:
         begin
            if (prog_i < 8'h40)
               tmp = 16'(prog_i) >> 1;
            else if (prog_i < 8'hc0)
               tmp = 16'h0020 + (((16'(prog_i) - 16'h0040) * 16'h0003) >> 1);
            else
               tmp = 16'h00e0 + ((16'(prog_i) - 16'h00c0) >> 1);
            weight_o = tmp[7:0];
         end
         STYLE_LUT_FIXED:  weight_o = base;
         STYLE_LUT_CORR:
         begin
            // low supply pulls the weight up so the swing is not lost
            tmp      = 16'(base) + ((16'(8'hff - base) * 16'(8'hff - supply_i)) >> 8);
            weight_o = tmp[7:0];
         end
         STYLE_LUT_NOCORR:
         begin
            tmp      = (16'(base) * 16'(supply_i)) >> 8;
            weight_o = tmp[7:0];
         end
         default:          weight_o = prog_i;
      endcase
   end

endmodule // esc_shape_weight
